// >>> rtl/sesq_pkg.sv
// Shared constants, modes and configuration carrier of the exposure sequencer
package sesq_pkg;

  // ----------------------------------------------------------------
  // Clock and timer granularity
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_PS = 5000;
  localparam int LOGIC_PERIOD_A_PS = 16129;
  localparam int LOGIC_PERIOD_B_PS = 64516;
  localparam int UNIT_A_CYC = (LOGIC_PERIOD_A_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int UNIT_B_CYC = (LOGIC_PERIOD_B_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [3:0] UNIT_A_M1 = 4'(UNIT_A_CYC - 1);
  localparam logic [3:0] UNIT_B_M1 = 4'(UNIT_B_CYC - 1);

  // ----------------------------------------------------------------
  // Overheads, readout geometry and monitor selection
  // ----------------------------------------------------------------
  localparam logic [15:0] ROT_CYCLES = 16'h0010;
  localparam logic [15:0] FOT_CYCLES = 16'h0040;
  localparam int KERNEL_SHIFT = 3;
  localparam int ROI_COUNT = 8;
  localparam logic [ROI_COUNT-1:0] ROI_SINGLE = 8'h01;
  localparam logic [2:0] MON_SEL_FIRST_LINE = 3'h5;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [10:0] LINE_RESET = 11'h000;

  // ----------------------------------------------------------------
  // Shutter modes and configuration carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SESQ_PIPELINED,
    SESQ_TRIG_MASTER,
    SESQ_TRIG_SLAVE,
    SESQ_ROLLING
  } sesq_mode_e;

  typedef struct packed {
    sesq_mode_e mode;
    logic variant_b;
    logic frame_time_programming_select;
    logic [15:0] frame_period_setting;
    logic [15:0] integration_length_setting;
    logic [15:0] reset_length_setting;
    logic [15:0] timer_multiplier;
    logic [10:0] active_lines;
    logic [10:0] padding_lines;
    logic [15:0] rolling_row_readout_length;
    logic [7:0] window_column_begin;
    logic [7:0] window_column_finish;
    logic [ROI_COUNT-1:0] roi_enable;
    logic [2:0] monitor_select;
  } sesq_cfg_s;

endpackage

// >>> rtl/sesq_trig_sync.sv
// Trigger pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module sesq_trig_sync
  import sesq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  // ----------------------------------------------------------------
  // Three-stage capture; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic lvl_d, rise_d, fall_d;

  // Next level only from agreeing later stages, first stage untouched
  always_comb
  begin
    lvl_d = lvl_q;
    if (s2_q == s3_q)
    begin
      lvl_d = s3_q;
    end
    rise_d = lvl_d & ~lvl_q;
    fall_d = ~lvl_d & lvl_q;
  end

  // Registers only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level_o = lvl_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RISE_NEEDS_PIN_HIGH: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_o |-> $past(s3_q) && $past(s2_q))
    else $error("rise pulse without settled high trigger");

  AST_LEVEL_FOLLOWS_AGREE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (s2_q && s3_q) |=> level_o)
    else $error("filtered trigger level did not follow agreeing stages");

endmodule
`default_nettype wire

// >>> rtl/sesq_top.sv
// Exposure and readout sequencer for global and rolling shutter operation
// Summary of operation
// - Scale timer settings by multiplier granule
// - Transfer in overhead, then timed photodiode reset
// - Release reset, expose for setting times multiplier
// - Exposure start during readout waits line boundary
// - Pipelined exposure extends until readout complete
// - Frame-time select derives reset from frame period
// - Triggered master starts on rising trigger only
// - Triggered master exposure extends until readout complete
// - Monitor select five flags first line
// - Slave: rise starts exposure, fall starts transfer
// - Slave exposure extends until readout complete
// - Rolling exposure counted in whole lines
// - Rolling adds padding lines without pixel data
// - Line time is overhead plus readout length
// - Readout length register, floored by window width
// - Eight windows global, one in rolling
// - Column begin times eight gives pixel column
`timescale 1ns/1ps
`default_nettype none
module sesq_top
  import sesq_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire sesq_cfg_s CFG_I,
  input wire logic EXPOSURE_TRIGGER_PIN_I,
  output logic PD_RESET_O,
  output logic STORE_XFER_O,
  output logic EXPOSING_O,
  output logic READOUT_BUSY_O,
  output logic LINE_VALID_O,
  output logic FIRST_LINE_INDICATOR_O,
  output logic [10:0] ROW_INDEX_O,
  output logic [10:0] ROLL_RESET_ROW_O,
  output logic [10:0] COL_START_PIX_O,
  output logic [ROI_COUNT-1:0] ROI_ACTIVE_O
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction

  // Last count of one logic-clock period, in system clock cycles
  function automatic logic [3:0] unit_last(input logic vb);
    unit_last = vb ? UNIT_B_M1 : UNIT_A_M1;
  endfunction

  typedef enum {
    ST_IDLE,
    ST_ARM,
    ST_FOT,
    ST_RESET,
    ST_WAIT_LINE,
    ST_EXPOSE,
    ST_HOLD
  } sesq_state_e;

  // ----------------------------------------------------------------
  // Trigger input
  // ----------------------------------------------------------------
  logic trig_lvl, trig_rise, trig_fall;

  sesq_trig_sync u_trig (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(EXPOSURE_TRIGGER_PIN_I),
    .level_o(trig_lvl),
    .rise_o(trig_rise),
    .fall_o(trig_fall)
  );

  // ----------------------------------------------------------------
  // Line geometry
  // ----------------------------------------------------------------
  logic rolling;
  logic [15:0] kernels;
  logic [15:0] line_len;
  logic [10:0] frame_lines;
  assign rolling = (CFG_I.mode == SESQ_ROLLING);
  // Window width floors the readout length, so a short setting never truncates a row
  assign kernels = {8'h00, CFG_I.window_column_finish - CFG_I.window_column_begin};
  assign line_len = ROT_CYCLES + max16(CFG_I.rolling_row_readout_length, kernels);
  // Padding lines only extend the rolling frame
  assign frame_lines = rolling ? 11'(CFG_I.active_lines + CFG_I.padding_lines)
                               : CFG_I.active_lines;

  // ----------------------------------------------------------------
  // Readout engine: line timer and row counter
  // ----------------------------------------------------------------
  logic rd_busy_q, rd_busy_d;
  logic [15:0] rd_tmr_q, rd_tmr_d;
  logic [10:0] rd_line_q, rd_line_d;
  logic line_end, rd_start;
  logic [3:0] rd_pre_q, rd_pre_d;
  logic rd_tick;

  // Line length is in logic-clock periods, so a prescaler paces the row timer
  assign rd_tick = (rd_pre_q == unit_last(CFG_I.variant_b));
  assign line_end = rd_busy_q && rd_tick && (rd_tmr_q == 16'(line_len - 16'h0001));

  // Rolling runs free; global readout starts when the overhead ends
  always_comb
  begin
    rd_busy_d = rd_busy_q;
    rd_tmr_d = rd_tmr_q;
    rd_line_d = rd_line_q;
    rd_pre_d = rd_tick ? 4'h0 : 4'(rd_pre_q + 4'h1);
    if (rd_start || (rolling && !rd_busy_q))
    begin
      rd_busy_d = (frame_lines != LINE_RESET);
      rd_tmr_d = TIMER_RESET;
      rd_line_d = LINE_RESET;
      rd_pre_d = 4'h0;
    end
    else if (line_end)
    begin
      rd_tmr_d = TIMER_RESET;
      if (rd_line_q == 11'(frame_lines - 11'h001))
      begin
        rd_line_d = LINE_RESET;
        rd_busy_d = rolling;
      end
      else
      begin
        rd_line_d = 11'(rd_line_q + 11'h001);
      end
    end
    else if (rd_busy_q && rd_tick)
    begin
      rd_tmr_d = 16'(rd_tmr_q + 16'h0001);
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      rd_busy_q <= 1'b0;
      rd_tmr_q <= TIMER_RESET;
      rd_line_q <= LINE_RESET;
      rd_pre_q <= 4'h0;
    end
    else
    begin
      rd_busy_q <= rd_busy_d;
      rd_tmr_q <= rd_tmr_d;
      rd_line_q <= rd_line_d;
      rd_pre_q <= rd_pre_d;
    end
  end

  // ----------------------------------------------------------------
  // Granule timer: logic-clock unit times multiplier
  // ----------------------------------------------------------------
  sesq_state_e st_q, st_d;
  logic [3:0] base_q, base_d, unit_m1;
  logic [15:0] mult_q, mult_d, gran_q, gran_d;
  logic unit_tick, gran_tick;

  assign unit_m1 = unit_last(CFG_I.variant_b);
  assign unit_tick = (base_q == unit_m1);
  assign gran_tick = unit_tick &&
                     ((mult_q == 16'(CFG_I.timer_multiplier - 16'h0001)) ||
                      (CFG_I.timer_multiplier == 16'h0000));

  // Restart on every state change so each phase is timed from its own start
  always_comb
  begin
    base_d = unit_tick ? 4'h0 : 4'(base_q + 4'h1);
    mult_d = gran_tick ? TIMER_RESET : (unit_tick ? 16'(mult_q + 16'h0001) : mult_q);
    gran_d = gran_tick ? 16'(gran_q + 16'h0001) : gran_q;
    if (st_d != st_q)
    begin
      base_d = 4'h0;
      mult_d = TIMER_RESET;
      gran_d = TIMER_RESET;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      base_q <= 4'h0;
      mult_q <= TIMER_RESET;
      gran_q <= TIMER_RESET;
    end
    else
    begin
      base_q <= base_d;
      mult_q <= mult_d;
      gran_q <= gran_d;
    end
  end

  // ----------------------------------------------------------------
  // Global shutter sequence
  // ----------------------------------------------------------------
  logic [15:0] reset_target, fot_cnt_q, fot_cnt_d;
  logic reset_done, exp_done;

  // Frame-time select leaves the remainder of the frame to reset
  assign reset_target = !CFG_I.frame_time_programming_select ? CFG_I.reset_length_setting :
    ((CFG_I.frame_period_setting > CFG_I.integration_length_setting) ?
     16'(CFG_I.frame_period_setting - CFG_I.integration_length_setting) : 16'h0000);
  assign reset_done = (gran_q >= reset_target);
  // Slave ends once the pin is low; a fall seen while waiting for a line is not lost
  assign exp_done = (CFG_I.mode == SESQ_TRIG_SLAVE) ? !trig_lvl :
                    (gran_q >= CFG_I.integration_length_setting);
  assign rd_start = (st_q == ST_FOT) && (fot_cnt_q == 16'(FOT_CYCLES - 16'h0001));

  always_comb
  begin
    st_d = st_q;
    fot_cnt_d = (st_q == ST_FOT) ? 16'(fot_cnt_q + 16'h0001) : TIMER_RESET;
    case (st_q)
      ST_IDLE:
      begin
        if (CFG_I.mode == SESQ_PIPELINED)
          st_d = ST_RESET;
        else if (!rolling)
          st_d = ST_ARM;
      end
      ST_ARM:
      begin
        // Only the rising edge arms exposure; falling edge is ignored here
        if (trig_rise)
          st_d = rd_busy_q ? ST_WAIT_LINE : ST_EXPOSE;
      end
      ST_RESET:
      begin
        if (reset_done)
          st_d = rd_busy_q ? ST_WAIT_LINE : ST_EXPOSE;
      end
      ST_WAIT_LINE:
      begin
        // Exposure may only open at a row boundary while readout runs
        if (line_end || !rd_busy_q)
          st_d = ST_EXPOSE;
      end
      ST_EXPOSE:
      begin
        if (exp_done)
          st_d = rd_busy_q ? ST_HOLD : ST_FOT;
      end
      ST_HOLD:
      begin
        if (!rd_busy_q)
          st_d = ST_FOT;
      end
      ST_FOT:
      begin
        if (rd_start)
          st_d = (CFG_I.mode == SESQ_PIPELINED) ? ST_RESET : ST_ARM;
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
    if (rolling)
      st_d = ST_IDLE;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      st_q <= ST_IDLE;
      fot_cnt_q <= TIMER_RESET;
    end
    else
    begin
      st_q <= st_d;
      fot_cnt_q <= fot_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic pd_q, xfer_q, exp_q, busy_q, lval_q, first_q;
  logic [10:0] row_q, rrow_q, col_q;
  logic [ROI_COUNT-1:0] roi_q;
  logic pd_d, xfer_d, exp_d, lval_d, first_d;
  logic [10:0] rrow_d, col_d, rrow_sum;
  logic [ROI_COUNT-1:0] roi_d;

  // Rolling reset pointer leads the read pointer by the exposure in lines
  assign rrow_sum = 11'(rd_line_d + CFG_I.integration_length_setting[10:0]);

  always_comb
  begin
    exp_d = (st_d == ST_EXPOSE) || (st_d == ST_HOLD);
    pd_d = !rolling && !exp_d;
    xfer_d = (st_d == ST_FOT);
    lval_d = rd_busy_d && (rd_line_d < CFG_I.active_lines);
    first_d = (CFG_I.monitor_select == MON_SEL_FIRST_LINE) && rd_busy_d &&
              (rd_line_d == LINE_RESET);
    rrow_d = (rrow_sum >= frame_lines) ? 11'(rrow_sum - frame_lines) : rrow_sum;
    col_d = 11'({3'h0, CFG_I.window_column_begin} << KERNEL_SHIFT);
    roi_d = rolling ? (CFG_I.roi_enable & ROI_SINGLE) : CFG_I.roi_enable;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      pd_q <= 1'b1;
      xfer_q <= 1'b0;
      exp_q <= 1'b0;
      busy_q <= 1'b0;
      lval_q <= 1'b0;
      first_q <= 1'b0;
      row_q <= LINE_RESET;
      rrow_q <= LINE_RESET;
      col_q <= LINE_RESET;
      roi_q <= '0;
    end
    else
    begin
      pd_q <= pd_d;
      xfer_q <= xfer_d;
      exp_q <= exp_d;
      busy_q <= rd_busy_d;
      lval_q <= lval_d;
      first_q <= first_d;
      row_q <= rd_line_d;
      rrow_q <= rrow_d;
      col_q <= col_d;
      roi_q <= roi_d;
    end
  end

  assign PD_RESET_O = pd_q;
  assign STORE_XFER_O = xfer_q;
  assign EXPOSING_O = exp_q;
  assign READOUT_BUSY_O = busy_q;
  assign LINE_VALID_O = lval_q;
  assign FIRST_LINE_INDICATOR_O = first_q;
  assign ROW_INDEX_O = row_q;
  assign ROLL_RESET_ROW_O = rrow_q;
  assign COL_START_PIX_O = col_q;
  assign ROI_ACTIVE_O = roi_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EXPOSE_AT_LINE_EDGE: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    ($rose(EXPOSING_O) && READOUT_BUSY_O) |-> (rd_tmr_q == TIMER_RESET && rd_pre_q == 4'h0))
    else $error("exposure opened away from a line boundary");

  AST_NO_FOT_DURING_READ: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_q != ST_FOT && st_d == ST_FOT) |-> !rd_busy_q)
    else $error("transfer started before readout finished");

  AST_HOLD_TILL_DONE: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_q == ST_HOLD && rd_busy_q) |=> (st_q == ST_HOLD))
    else $error("exposure left extension while readout busy");

  AST_FOT_LENGTH: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    rd_start |-> ($past(st_q, 63) == ST_FOT) && (st_q == ST_FOT))
    else $error("frame overhead length wrong");

  AST_SLAVE_FALL_ENDS: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_q == ST_EXPOSE && CFG_I.mode == SESQ_TRIG_SLAVE && trig_lvl) |=>
    (st_q == ST_EXPOSE || rolling || CFG_I.mode != SESQ_TRIG_SLAVE))
    else $error("slave exposure ended without falling trigger");

  AST_ARM_NEEDS_RISE: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (st_q == ST_ARM && st_d != ST_ARM && !rolling) |-> trig_rise)
    else $error("armed sequence left without trigger rise");

  AST_PD_VS_EXPOSE: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    EXPOSING_O |-> !PD_RESET_O)
    else $error("photodiode reset held during exposure");

  AST_FIRST_LINE_FLAG: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    FIRST_LINE_INDICATOR_O |-> (ROW_INDEX_O == LINE_RESET) && READOUT_BUSY_O &&
    ($past(CFG_I.monitor_select) == MON_SEL_FIRST_LINE))
    else $error("first line flag outside first line");

  AST_ROLL_ONE_ROI: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $past(rolling) |-> (ROI_ACTIVE_O[ROI_COUNT-1:1] == '0))
    else $error("more than one window in rolling mode");

  AST_COL_SCALE: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> (COL_START_PIX_O == 11'({3'h0, $past(CFG_I.window_column_begin)} << 3)))
    else $error("column start not scaled by eight");

  COV_PIPE_CYCLE: cover property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == ST_RESET ##1 st_q == ST_EXPOSE);
  COV_WAIT_LINE: cover property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == ST_WAIT_LINE ##1 st_q == ST_EXPOSE);
  COV_HOLD: cover property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == ST_HOLD ##1 st_q == ST_FOT);
  COV_ROLL_WRAP: cover property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    rolling && line_end && rd_line_d == LINE_RESET);
  COV_SLAVE_LATE_FALL: cover property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    CFG_I.mode == SESQ_TRIG_SLAVE && st_q == ST_WAIT_LINE && trig_fall);

endmodule
`default_nettype wire

// >>> sim/sesq_trig_model.sv
// Behavioural external controller that pulses the trigger pin and watches the first-line flag
`timescale 1ns/1ps
`default_nettype none
module sesq_trig_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic [15:0] hold_i,
  input wire logic store_xfer_i,
  input wire logic first_line_i,
  output logic trig_o,
  output logic ready_o
);
  // ----------------------------------------------------------------
  // Trigger pulse generation
  // ----------------------------------------------------------------
  initial
  begin
    trig_o = 1'b0;
    ready_o = 1'b1;
  end

  // One pulse per request; pin changes only on the falling clock edge
  always
  begin
    @(posedge clk_i);
    if (fire_i === 1'b1)
    begin
      @(negedge clk_i);
      // Never rise while the storage transfer runs
      while (store_xfer_i === 1'b1) @(negedge clk_i);
      trig_o <= 1'b1;
      ready_o <= 1'b0;
      // Short requests are stretched to the minimum high time
      repeat ((hold_i < 16'h0014) ? 16'h0014 : hold_i) @(negedge clk_i);
      trig_o <= 1'b0;
      // Next pulse only after the first line is flagged; a reset frees the wait
      while (first_line_i !== 1'b1 && rst_n_i === 1'b1) @(negedge clk_i);
      ready_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/test_shutter_exposure_sequencer.sv
// Self-checking testbench of the exposure sequencer in all four shutter modes
`timescale 1ns/1ps
`default_nettype none
module test_shutter_exposure_sequencer
  import sesq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sesq_cfg_s cfg = '0;
  logic fire = 1'b0;
  logic [15:0] hold = 16'h0000;
  logic trig;
  logic ready;
  logic pd_reset, store_xfer, exposing, busy, line_valid, first_line;
  logic [10:0] row, roll_row, col_pix;
  logic [ROI_COUNT-1:0] roi_act;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // Clock, design, controller model and hang guard
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  sesq_top DUT (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CFG_I(cfg), .EXPOSURE_TRIGGER_PIN_I(trig),
    .PD_RESET_O(pd_reset), .STORE_XFER_O(store_xfer), .EXPOSING_O(exposing),
    .READOUT_BUSY_O(busy), .LINE_VALID_O(line_valid), .FIRST_LINE_INDICATOR_O(first_line),
    .ROW_INDEX_O(row), .ROLL_RESET_ROW_O(roll_row), .COL_START_PIX_O(col_pix),
    .ROI_ACTIVE_O(roi_act));

  sesq_trig_model ctrl (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .hold_i(hold),
    .store_xfer_i(store_xfer), .first_line_i(first_line), .trig_o(trig), .ready_o(ready));

  // Whole run needs a few thousand cycles; the ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check_bit(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  // Measured cycle counts carry a small tolerance for register stages
  task automatic check_near(input string nm, input int e, input int s, input int tol);
    n_tests++;
    if (s < e - tol || s > e + tol)
    begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
      bad_count++;
    end
  endtask

  // ----------------------------------------------------------------
  // Stimulus and measurement helpers
  // ----------------------------------------------------------------
  function automatic logic pick(input int s);
    case (s)
      0: return exposing;
      1: return store_xfer;
      2: return first_line;
      3: return trig;
      default: return busy;
    endcase
  endfunction

  // Counts falling edges until the chosen signal shows the level
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v)
    begin
      @(negedge clk);
      n++;
      if (n > 8000)
      begin
        bad_count++;
        complete_run();
      end
    end
  endtask

  task automatic wait_row(output int n);
    logic [10:0] r;
    r = row;
    n = 0;
    while (row === r)
    begin
      @(negedge clk);
      n++;
      if (n > 8000)
      begin
        bad_count++;
        complete_run();
      end
    end
  endtask

  // Configuration is only changed while reset is held
  task automatic start(input sesq_mode_e m, input logic vb, input logic fts,
    input int fr, input int ig, input int rl, input int ml, input int rd);
    @(negedge clk);
    rst_n = 1'b0;
    cfg = '{m, vb, fts, 16'(fr), 16'(ig), 16'(rl), 16'(ml), 11'h003, 11'h002, 16'(rd),
      8'h02, 8'h1E, 8'h5B, MON_SEL_FIRST_LINE};
    repeat (6) @(negedge clk);
    check_bit("pd_reset_in_reset", 1'b1, pd_reset);
    check_bit("exposing_in_reset", 1'b0, exposing);
    rst_n = 1'b1;
  endtask

  // Fires as soon as the controller allows, so later pulses land during readout
  task automatic fire_pulse(input logic [15:0] h);
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    hold = h;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int rl_t[3] = '{3, 0, 2};
    int ig_t[3] = '{10, 10, 5};
    int ml_t[3] = '{2, 1, 1};
    int fr_t[3] = '{0, 20, 0};
    int n, u, inv;
    // Pipelined: plain, frame-time programmed, second timer granule
    for (int i = 0; i < 3; i++)
    begin
      start(SESQ_PIPELINED, i == 2, i == 1, fr_t[i], ig_t[i], rl_t[i], ml_t[i], 20);
      u = (i == 2) ? UNIT_B_CYC : UNIT_A_CYC;
      wait_lvl(0, 1'b1, n);
      check_near("reset_phase", ((i == 1) ? fr_t[i] - ig_t[i] : rl_t[i]) * ml_t[i] * u, n, 3);
      wait_lvl(0, 1'b0, n);
      check_near("exposure_len", ig_t[i] * ml_t[i] * u, n, 2);
      check_val("col_start_pix", 16'h0010, 16'(col_pix));
      check_val("roi_global", 16'h005B, 16'(roi_act));
      if (i == 0)
      begin
        // Second frame starts during readout and is too short to cover it
        wait_lvl(0, 1'b1, n);
        wait_lvl(0, 1'b0, n);
        check_bit("busy_at_exposure_end", 1'b0, busy);
      end
    end
    // Triggered master: only the rising edge counts
    start(SESQ_TRIG_MASTER, 1'b0, 1'b0, 256, 10, 3, 1, 20);
    repeat (100) @(negedge clk);
    check_bit("idle_without_trigger", 1'b0, exposing);
    fire_pulse(16'h001E);
    wait_lvl(3, 1'b1, n);
    wait_lvl(0, 1'b1, n);
    check_near("trigger_to_exposure", 5, n, 3);
    wait_lvl(0, 1'b0, n);
    check_near("trig_exposure_len", 10 * UNIT_A_CYC, n, 2);
    wait_lvl(2, 1'b1, n);
    check_val("first_line_row", 16'h0000, 16'(row));
    check_bit("first_line_busy", 1'b1, busy);
    fire_pulse(16'h001E);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    check_bit("trig_busy_at_end", 1'b0, busy);
    // Slave: pin high time is the exposure, settings ignored
    start(SESQ_TRIG_SLAVE, 1'b0, 1'b0, 256, 10, 3, 3, 20);
    fire_pulse(16'h0032);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    check_near("slave_exposure_len", 50, n, 2);
    wait_lvl(1, 1'b1, n);
    check_near("fall_to_transfer", 2, n, 2);
    fire_pulse(16'h0014);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    check_bit("slave_busy_at_end", 1'b0, busy);
    // Rolling: line time from overhead and widest of length or window
    start(SESQ_ROLLING, 1'b0, 1'b0, 256, 3, 3, 5, 20);
    repeat (4) @(negedge clk);
    check_bit("rolling_pd_reset", 1'b0, pd_reset);
    check_val("roi_rolling", 16'h0001, 16'(roi_act));
    wait_row(n);
    wait_row(n);
    check_near("line_time", (int'(ROT_CYCLES) + 28) * UNIT_A_CYC, n, 0);
    inv = 0;
    for (int k = 0; k < 5; k++)
    begin
      wait_row(n);
      repeat (2) @(negedge clk);
      if (line_valid === 1'b0)
        inv++;
      check_val("roll_reset_row", 16'((row + 11'h003) % 11'h005), 16'(roll_row));
    end
    check_near("padding_rows", 2, inv, 0);
    complete_run();
  end
endmodule
`default_nettype wire
